// ### occ_pkg.sv
// Constants, types and register layout of the output compare channel.
// Assumes a single 200 MHz clock domain and a plain strobe register port.
//
// What this block does
// - Middle control bits read zero, ignore writes.
// - Fault flag set by fault, control write clears.
// - Timebase select: one picks second timebase.
// - Mode 111: PWM with fault input active.
// - Mode 110: PWM, fault input ignored.
// - Mode 101: start low, continuous pulses.
// - Mode 100: start low, one pulse.
// - Mode 011: each compare toggles pin.
// - Mode 010: start high, compare drives low.
// - Mode 001: start low, compare drives high.
// - Mode 000: channel disabled, pin idle.
// - Idle-stop bit halts channel in idle.
`default_nettype none
package occ_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    // Register offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CMP_PRI = 4'h1;
    localparam logic [3:0] OFF_CMP_SEC = 4'h2;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h3;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
    // Control field positions
    localparam int unsigned POS_IDLE_STOP = 13;
    localparam int unsigned POS_FAULT = 4;
    localparam int unsigned POS_TSEL = 3;
    localparam int unsigned POS_MODE = 0;
    // Reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // Interrupt status bits
    localparam int unsigned IRQ_CMP = 0;
    localparam int unsigned IRQ_FAULT = 1;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'h0,
        OCC_MODE_SET = 3'h1,
        OCC_MODE_CLR = 3'h2,
        OCC_MODE_TOG = 3'h3,
        OCC_MODE_ONE = 3'h4,
        OCC_MODE_CONT = 3'h5,
        OCC_MODE_PWM = 3'h6,
        OCC_MODE_PWMF = 3'h7
    } occ_mode_t;

    typedef struct packed {
        logic idle_stop_control;
        logic timebase_select;
        occ_mode_t channel_mode_field;
    } occ_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } occ_bus_req_t;
endpackage : occ_pkg
`default_nettype wire

// ### occ_cmp_mem.sv
// Two-word compare value store with registered read data.
// Assumes a write and the word select come from the same clock domain.
`default_nettype none
module occ_cmp_mem
    import occ_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] pri_q,
    output logic [DATA_W-1:0] sec_q
);
    // Primary and secondary compare words
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pri_q <= RST_CMP;
            sec_q <= RST_CMP;
        end else if (ce && wr_en) begin
            if (wr_sel) begin
                sec_q <= wr_data;
            end else begin
                pri_q <= wr_data;
            end
        end
    end
endmodule : occ_cmp_mem
`default_nettype wire

// ### occ_channel.sv
// Output compare channel: control register, compare logic, pin and irq.
// Assumes timer counts arrive from logic on the same clock; the fault pin
// and idle indication are asynchronous and get synchronised here.
//
// Decided for this implementation: strobed register access and the address map.
`default_nettype none
module occ_channel
    import occ_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [15:0] first_timebase_count,
    input wire logic [15:0] second_timebase_count,
    input wire logic idle_mode,
    input wire logic fault_n,
    output logic compare_output_pin,
    output logic irq
);
    occ_ctrl_t ctrl_q;
    logic pwm_fault_flag_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic pin_q;
    logic irq_q;
    logic one_done_q;
    logic [15:0] count_prev_q;
    logic [1:0] fault_sync_q;
    logic [1:0] idle_sync_q;
    logic [DATA_W-1:0] cmp_pri;
    logic [DATA_W-1:0] cmp_sec;
    logic [15:0] count;
    logic run;
    logic hit_pri;
    logic hit_sec;
    logic fault_now;
    logic ctrl_wr;
    logic pwm_mode;

    // Register field packing for reads
    function automatic logic [DATA_W-1:0] pack_ctrl(input occ_ctrl_t c,
                                                    input logic flt);
        logic [DATA_W-1:0] v;
        v = '0;
        v[POS_IDLE_STOP] = c.idle_stop_control;
        v[POS_FAULT] = flt;
        v[POS_TSEL] = c.timebase_select;
        v[POS_MODE +: 3] = c.channel_mode_field;
        return v;
    endfunction : pack_ctrl

    occ_cmp_mem u_mem (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .wr_en(wr && (addr == OFF_CMP_PRI || addr == OFF_CMP_SEC)),
        .wr_sel(addr == OFF_CMP_SEC),
        .wr_data(wdata),
        .pri_q(cmp_pri),
        .sec_q(cmp_sec)
    );

    // Two-flop synchronisers for fault pin and idle indication
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_sync_q <= 2'h0;
            idle_sync_q <= 2'h0;
        end else if (ce) begin
            fault_sync_q <= {fault_sync_q[0], ~fault_n};
            idle_sync_q <= {idle_sync_q[0], idle_mode};
        end
    end

    // Timebase choice, run gate and compare detection
    assign count = ctrl_q.timebase_select ? second_timebase_count
                                          : first_timebase_count;
    assign run = !(ctrl_q.idle_stop_control && idle_sync_q[1]);
    assign ctrl_wr = wr && (addr == OFF_CTRL);
    // Hit only when count reaches the value, not while it sits there
    assign hit_pri = run && (count == cmp_pri)
                     && (count_prev_q != cmp_pri);
    assign hit_sec = run && (count == cmp_sec)
                     && (count_prev_q != cmp_sec);
    assign pwm_mode = ctrl_q.channel_mode_field == OCC_MODE_PWM
                      || ctrl_q.channel_mode_field == OCC_MODE_PWMF;
    assign fault_now = run && fault_sync_q[1]
                       && ctrl_q.channel_mode_field == OCC_MODE_PWMF;

    // Previous count for edge-style equality detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_prev_q <= 16'h0000;
        end else if (ce) begin
            count_prev_q <= count;
        end
    end

    // Control register; middle bits are simply never stored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q.idle_stop_control <= RST_CTRL[POS_IDLE_STOP];
            ctrl_q.timebase_select <= RST_CTRL[POS_TSEL];
            ctrl_q.channel_mode_field <= occ_mode_t'(RST_CTRL[POS_MODE +: 3]);
        end else if (ce && ctrl_wr) begin
            ctrl_q.idle_stop_control <= wdata[POS_IDLE_STOP];
            ctrl_q.timebase_select <= wdata[POS_TSEL];
            ctrl_q.channel_mode_field <= occ_mode_t'(wdata[POS_MODE +: 3]);
        end
    end

    // Fault flag: set by fault, cleared by a control register write; set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_fault_flag_q <= 1'b0;
        end else if (ce) begin
            if (fault_now) begin
                pwm_fault_flag_q <= 1'b1;
            end else if (ctrl_wr) begin
                pwm_fault_flag_q <= 1'b0;
            end
        end
    end

    // Single-pulse completion tracker
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            one_done_q <= 1'b0;
        end else if (ce) begin
            if (ctrl_wr) begin
                one_done_q <= 1'b0;
            end else if (ctrl_q.channel_mode_field == OCC_MODE_ONE
                         && pin_q && hit_sec) begin
                one_done_q <= 1'b1;
            end
        end
    end

    // Output pin behaviour per mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_q <= 1'b0;
        end else if (ce) begin
            if (ctrl_wr) begin
                // Initial level on (re)programming
                case (occ_mode_t'(wdata[POS_MODE +: 3]))
                    OCC_MODE_CLR: pin_q <= 1'b1;
                    OCC_MODE_TOG: pin_q <= pin_q;
                    default: pin_q <= 1'b0;
                endcase
            end else if (pwm_fault_flag_q || fault_now) begin
                pin_q <= 1'b0;
            end else begin
                case (ctrl_q.channel_mode_field)
                    OCC_MODE_OFF: pin_q <= 1'b0;
                    OCC_MODE_SET: begin
                        if (hit_pri) begin
                            pin_q <= 1'b1;
                        end
                    end
                    OCC_MODE_CLR: begin
                        if (hit_pri) begin
                            pin_q <= 1'b0;
                        end
                    end
                    OCC_MODE_TOG: begin
                        if (hit_pri) begin
                            pin_q <= ~pin_q;
                        end
                    end
                    OCC_MODE_ONE: begin
                        if (hit_pri && !one_done_q && !pin_q) begin
                            pin_q <= 1'b1;
                        end else if (hit_sec && pin_q) begin
                            pin_q <= 1'b0;
                        end
                    end
                    OCC_MODE_CONT, OCC_MODE_PWM, OCC_MODE_PWMF: begin
                        // rise on primary, fall on secondary
                        if (hit_pri) begin
                            pin_q <= 1'b1;
                        end else if (hit_sec) begin
                            pin_q <= 1'b0;
                        end
                    end
                    default: pin_q <= 1'b0;
                endcase
            end
        end
    end

    // Sticky interrupt status; read clears, set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= RST_IRQ;
        end else if (ce) begin
            if (rd && addr == OFF_IRQ_STAT) begin
                irq_stat_q <= 2'h0;
            end
            if (hit_pri && ctrl_q.channel_mode_field != OCC_MODE_OFF
                && !pwm_mode) begin
                irq_stat_q[IRQ_CMP] <= 1'b1;
            end else if (hit_pri && pwm_mode) begin
                irq_stat_q[IRQ_CMP] <= 1'b1;
            end
            if (fault_now) begin
                irq_stat_q[IRQ_FAULT] <= 1'b1;
            end
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask_q <= RST_IRQ;
        end else if (ce && wr && addr == OFF_IRQ_MASK) begin
            irq_mask_q <= wdata[1:0];
        end
    end

    // Registered interrupt output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= '0;
            if (rd) begin
                case (addr)
                    OFF_CTRL: rdata_q <= pack_ctrl(ctrl_q,
                                                   pwm_fault_flag_q);
                    OFF_CMP_PRI: rdata_q <= cmp_pri;
                    OFF_CMP_SEC: rdata_q <= cmp_sec;
                    OFF_IRQ_STAT: rdata_q <= {14'h0000, irq_stat_q};
                    OFF_IRQ_MASK: rdata_q <= {14'h0000, irq_mask_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign rdata = rdata_q;
    assign compare_output_pin = pin_q;
    assign irq = irq_q;
endmodule : occ_channel
`default_nettype wire

// ### occ_channel_sva.sv
// Port checks for the output compare channel.
// Assumes it is bound to occ_channel on one clock domain.
`default_nettype none
module occ_channel_sva
    import occ_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [15:0] first_timebase_count,
    input wire logic [15:0] second_timebase_count,
    input wire logic idle_mode,
    input wire logic fault_n,
    input wire logic compare_output_pin,
    input wire logic irq
);
    logic [15:0] ctrl_q;
    logic [15:0] pri_q;
    logic [15:0] cnt;
    logic wc;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Shadow copies of control and primary compare
    assign wc = wr && ce && addr == OFF_CTRL;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 16'h0000;
            pri_q <= 16'h0000;
        end else if (wr && ce) begin
            if (addr == OFF_CTRL) ctrl_q <= wdata;
            if (addr == OFF_CMP_PRI) pri_q <= wdata;
        end
    end
    // Count of the selected timebase
    assign cnt = ctrl_q[3] ? second_timebase_count : first_timebase_count;
    mid_zero_a: assert property (
        rd && ce && addr == OFF_CTRL |=> rdata[15:14] == 2'h0
        && rdata[12:5] == 8'h00) else $error("control unused bits set");
    init_high_a: assert property (
        wc && wdata[2:0] == 3'h2 |=> compare_output_pin)
        else $error("pin not high after mode write");
    init_low_a: assert property (
        wc && wdata[2:0] inside {3'h0, 3'h1, 3'h4, 3'h5}
        |=> !compare_output_pin) else $error("pin not low after mode write");
    tog_keep_a: assert property (
        wc && wdata[2:0] == 3'h3 |=> $stable(compare_output_pin))
        else $error("toggle mode write moved pin");
    set_hit_a: assert property (
        ctrl_q[2:0] == 3'h1 && !ctrl_q[13] && ce && !wr && cnt == pri_q
        && $past(cnt) != pri_q |=> compare_output_pin)
        else $error("compare did not set pin");
    tog_hit_a: assert property (
        ctrl_q[2:0] == 3'h3 && !ctrl_q[13] && ce && !wr && cnt == pri_q
        && $past(cnt) != pri_q
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("compare did not toggle pin");
    off_quiet_a: assert property (
        ctrl_q[2:0] == 3'h0 && !wc |=> !compare_output_pin)
        else $error("disabled channel drove pin");
    fault_low_a: assert property (
        (ctrl_q[2:0] == 3'h7 && !ctrl_q[13] && !wc && !fault_n) [*3]
        |=> !compare_output_pin) else $error("fault did not force pin low");
endmodule : occ_channel_sva
bind occ_channel occ_channel_sva i_sva (.clk(clk), .resetn(resetn),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .first_timebase_count(first_timebase_count),
    .second_timebase_count(second_timebase_count), .idle_mode(idle_mode),
    .fault_n(fault_n), .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire

// ### output_compare_channel_tb.sv
// Self-checking bench for the output compare channel.
// Assumes occ_pkg, occ_channel and its checker are compiled first.
`default_nettype none
module output_compare_channel_tb
    import occ_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic [15:0] tc [2] = '{16'h0000, 16'h0000};
    logic idle = 1'b0;
    logic fault_n = 1'b1;
    logic pin;
    logic irq;
    int err_count = 0;
    int checks = 0;
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    occ_channel i_dut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .first_timebase_count(tc[0]), .second_timebase_count(tc[1]),
        .idle_mode(idle), .fault_n(fault_n), .compare_output_pin(pin),
        .irq(irq));
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic pin_is(input logic e);
        #1;
        chk("pin", {15'h0000, pin}, {15'h0000, e});
    endtask : pin_is
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask : rd_chk
    // Count arrives at v from v-1 on timebase s, which need not be the selected one
    task automatic hit(input logic s, input logic [15:0] v, input logic e);
        @(posedge clk);
        tc[s] <= v - 16'h0001;
        @(posedge clk);
        tc[s] <= v;
        repeat (2) @(posedge clk);
        pin_is(e);
    endtask : hit
    task automatic flt(input logic e);
        @(posedge clk);
        fault_n <= 1'b0;
        repeat (4) @(posedge clk);
        fault_n <= 1'b1;
        pin_is(e);
    endtask : flt
    task automatic finish_test;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(OFF_CTRL, RST_CTRL);
        wr_reg(OFF_CTRL, 16'hFFFF);
        rd_chk(OFF_CTRL, 16'h200F);
        rd_chk(4'h7, 16'h0000);
        wr_reg(OFF_CMP_PRI, 16'h0005);
        wr_reg(OFF_CMP_SEC, 16'h0008);
        for (int m = 1; m < 4; m++) begin
            wr_reg(OFF_CTRL, 16'(m));
            pin_is(m == 2);
            hit(1'b0, 16'h0005, m != 2);
        end
        hit(1'b0, 16'h0005, 1'b0);
        wr_reg(OFF_CTRL, 16'h0009);
        hit(1'b0, 16'h0005, 1'b0);
        hit(1'b1, 16'h0005, 1'b1);
        wr_reg(OFF_CTRL, 16'h0000);
        hit(1'b0, 16'h0005, 1'b0);
        for (int m = 4; m < 6; m++) begin
            wr_reg(OFF_CTRL, 16'(m));
            hit(1'b0, 16'h0005, 1'b1);
            hit(1'b0, 16'h0008, 1'b0);
            hit(1'b0, 16'h0005, m == 5);
        end
        wr_reg(OFF_CTRL, 16'h0006);
        hit(1'b0, 16'h0005, 1'b1);
        flt(1'b1);
        rd_chk(OFF_CTRL, 16'h0006);
        wr_reg(OFF_CTRL, 16'h0007);
        hit(1'b0, 16'h0005, 1'b1);
        flt(1'b0);
        rd_chk(OFF_CTRL, 16'h0017);
        hit(1'b0, 16'h0005, 1'b0);
        // Masked, then unmasked, then read-cleared interrupt
        chk("irq", {15'h0000, irq}, 16'h0000);
        wr_reg(OFF_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge clk);
        chk("irq", {15'h0000, irq}, 16'h0001);
        rd_chk(OFF_IRQ_STAT, 16'h0003);
        repeat (2) @(posedge clk);
        chk("irq", {15'h0000, irq}, 16'h0000);
        rd_chk(OFF_IRQ_STAT, 16'h0000);
        wr_reg(OFF_CTRL, 16'h0007);
        rd_chk(OFF_CTRL, 16'h0007);
        wr_reg(OFF_CTRL, 16'h2001);
        idle <= 1'b1;
        hit(1'b0, 16'h0005, 1'b0);
        wr_reg(OFF_CTRL, 16'h0001);
        hit(1'b0, 16'h0005, 1'b1);
        // Clock enable low: a control write must be ignored
        ce <= 1'b0;
        wr_reg(OFF_CTRL, 16'h0002);
        ce <= 1'b1;
        pin_is(1'b1);
        rd_chk(OFF_CTRL, 16'h0001);
        finish_test();
    end
    // Hang guard
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule : output_compare_channel_tb
`default_nettype wire
